// >>> include/tcu_pkg.sv
// package for the 8-bit timer counter unit: register map, field layout, modes
// assumes a byte-wide register port with one-cycle read latency
package tcu_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [3:0] TCU_ADDR_CTRL_A  = 4'h0;  // control_register_a
  localparam logic [3:0] TCU_ADDR_CTRL_B  = 4'h1;  // control_register_b
  localparam logic [3:0] TCU_ADDR_COUNT   = 4'h2;  // counter_value
  localparam logic [3:0] TCU_ADDR_CMP_A   = 4'h3;  // compare_value_a
  localparam logic [3:0] TCU_ADDR_CMP_B   = 4'h4;  // compare_value_b
  localparam logic [3:0] TCU_ADDR_MASK    = 4'h5;  // timer_mask_register
  localparam logic [3:0] TCU_ADDR_FLAG    = 4'h6;  // timer_flag_register
  localparam logic [3:0] TCU_ADDR_TICKSRC = 4'h7;  // not decoded: reads return zero, writes have no effect

  // ------------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------------
  localparam int TCU_WGM_LO_POS = 0;  // waveform mode bits 1:0 in control_register_a
  localparam int TCU_COM_B_POS  = 4;  // compare output b mode, 2 bits
  localparam int TCU_COM_A_POS  = 6;  // compare output a mode, 2 bits
  localparam int TCU_CS_POS     = 0;  // clock_select_field, 3 bits in control_register_b
  localparam int TCU_WGM_HI_POS = 3;  // waveform mode bit 2 in control_register_b
  localparam int TCU_FLG_OVF    = 0;
  localparam int TCU_FLG_CMPA   = 1;
  localparam int TCU_FLG_CMPB   = 2;

  // ------------------------------------------------------------------
  // values
  // ------------------------------------------------------------------
  localparam logic [7:0] TCU_BOTTOM    = 8'h00;
  localparam logic [7:0] TCU_MAX       = 8'hff;
  localparam logic [7:0] TCU_RESET_VAL = 8'h00;
  localparam logic [7:0] TCU_ONE       = 8'h01;

  // clock select codes
  localparam logic [2:0] TCU_CS_STOP   = 3'h0;
  localparam logic [2:0] TCU_CS_DIV1   = 3'h1;
  localparam logic [2:0] TCU_CS_DIV8   = 3'h2;
  localparam logic [2:0] TCU_CS_DIV64  = 3'h3;
  localparam logic [2:0] TCU_CS_DIV256 = 3'h4;
  localparam logic [2:0] TCU_CS_DIV1K  = 3'h5;
  localparam logic [2:0] TCU_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TCU_CS_EXT_RISE = 3'h7;

  // waveform modes
  localparam logic [2:0] TCU_WGM_NORMAL    = 3'h0;
  localparam logic [2:0] TCU_WGM_PC_MAX    = 3'h1;
  localparam logic [2:0] TCU_WGM_CTC       = 3'h2;
  localparam logic [2:0] TCU_WGM_FAST_MAX  = 3'h3;
  localparam logic [2:0] TCU_WGM_PC_OCRA   = 3'h5;
  localparam logic [2:0] TCU_WGM_FAST_OCRA = 3'h7;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tcu_req_t;

  // flag group
  typedef struct packed {
    logic cmp_b;
    logic cmp_a;
    logic ovf;
  } tcu_evt_t;

endpackage : tcu_pkg

// >>> src/tcu_counter_unit.sv
// 8-bit timer counter unit with two compare channels, flags, masks and waveform outputs
// assumes a byte register port (read data one cycle after the strobe) and an
// external count pin already synchronous to core_clk_i
`timescale 1ns/1ps
`default_nettype none

module tcu_counter_unit
  import tcu_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  // register port
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // interrupt
  input  wire logic       irq_ack_ovf_i,
  input  wire logic       irq_ack_cmpa_i,
  input  wire logic       irq_ack_cmpb_i,
  output logic            irq_o,
  // pins
  input  wire logic       external_count_pin_i,
  output logic            compare_output_a_o,
  output logic            compare_output_b_o
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [7:0] counter_value_r;
  logic [7:0] compare_value_a_r;
  logic [7:0] compare_value_b_r;
  logic [7:0] cmp_buf_a_r;
  logic [7:0] cmp_buf_b_r;
  logic [2:0] mask_r;
  logic [2:0] flag_r;
  logic [9:0] presc_r;
  logic       ext_prev_r;
  logic       dir_down_r;
  logic       blk_r;
  logic       oc_a_r;
  logic       oc_b_r;

  tcu_req_t req;
  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  wire wr_ctrl_a = req.wr && (req.addr == TCU_ADDR_CTRL_A);
  wire wr_ctrl_b = req.wr && (req.addr == TCU_ADDR_CTRL_B);
  wire wr_count  = req.wr && (req.addr == TCU_ADDR_COUNT);
  wire wr_cmp_a  = req.wr && (req.addr == TCU_ADDR_CMP_A);
  wire wr_cmp_b  = req.wr && (req.addr == TCU_ADDR_CMP_B);
  wire wr_mask   = req.wr && (req.addr == TCU_ADDR_MASK);
  wire wr_flag   = req.wr && (req.addr == TCU_ADDR_FLAG);

  wire [2:0] cs_sel = ctrl_b_r[TCU_CS_POS +: 3];
  wire [2:0] wgm    = {ctrl_b_r[TCU_WGM_HI_POS], ctrl_a_r[TCU_WGM_LO_POS +: 2]};
  wire [1:0] com_a  = ctrl_a_r[TCU_COM_A_POS +: 2];
  wire [1:0] com_b  = ctrl_a_r[TCU_COM_B_POS +: 2];

  // ------------------------------------------------------------------
  // tick selection
  // ------------------------------------------------------------------
  wire ext_rise = external_count_pin_i && !ext_prev_r;
  wire ext_fall = !external_count_pin_i && ext_prev_r;
  logic timer_tick;
  always_comb begin
    case (cs_sel)
      TCU_CS_STOP:     timer_tick = 1'b0;
      TCU_CS_DIV1:     timer_tick = 1'b1;
      TCU_CS_DIV8:     timer_tick = (presc_r[2:0] == 3'h7);
      TCU_CS_DIV64:    timer_tick = (presc_r[5:0] == 6'h3f);
      TCU_CS_DIV256:   timer_tick = (presc_r[7:0] == 8'hff);
      TCU_CS_DIV1K:    timer_tick = (presc_r == 10'h3ff);
      TCU_CS_EXT_FALL: timer_tick = ext_fall;
      TCU_CS_EXT_RISE: timer_tick = ext_rise;
      default:         timer_tick = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------------
  wire mode_pwm   = (wgm == TCU_WGM_PC_MAX) || (wgm == TCU_WGM_FAST_MAX) ||
                    (wgm == TCU_WGM_PC_OCRA) || (wgm == TCU_WGM_FAST_OCRA);
  wire mode_pc    = (wgm == TCU_WGM_PC_MAX) || (wgm == TCU_WGM_PC_OCRA);
  wire mode_clear = (wgm == TCU_WGM_CTC) || (wgm == TCU_WGM_FAST_MAX) || (wgm == TCU_WGM_FAST_OCRA);
  wire top_is_a   = (wgm == TCU_WGM_CTC) || (wgm == TCU_WGM_PC_OCRA) || (wgm == TCU_WGM_FAST_OCRA);

  wire [7:0] top_val  = top_is_a ? compare_value_a_r : TCU_MAX;
  wire       at_bot   = (counter_value_r == TCU_BOTTOM);
  wire       at_max   = (counter_value_r == TCU_MAX);
  wire       at_top   = (counter_value_r == top_val);
  wire       match_a  = (counter_value_r == compare_value_a_r);
  wire       match_b  = (counter_value_r == compare_value_b_r);

  // direction: phase correct turns down at top and up at bottom
  wire dir_down = mode_pc && (at_top ? 1'b1 : (at_bot ? 1'b0 : dir_down_r));

  logic [7:0] count_nxt;
  always_comb begin
    if (mode_clear && at_top) begin
      count_nxt = TCU_BOTTOM;
    end else if (dir_down) begin
      count_nxt = counter_value_r - TCU_ONE;
    end else begin
      count_nxt = counter_value_r + TCU_ONE;
    end
  end

  // overflow point: wrap to zero in non-pwm and fast, bottom in phase correct
  wire ovf_evt = timer_tick && (mode_pc ? at_bot : (count_nxt == TCU_BOTTOM));

  // compare buffers load at top in phase correct, on the wrap to zero in fast; direct otherwise
  wire buf_load = mode_pwm && timer_tick && (mode_pc ? at_top : (count_nxt == TCU_BOTTOM));

  // a counter write blocks compare flags, and compare pin changes in non-pwm modes, on the next tick
  wire cmp_a_evt = timer_tick && match_a && !blk_r;
  wire cmp_b_evt = timer_tick && match_b && !blk_r;

  tcu_evt_t evt;
  assign evt = '{cmp_b: cmp_b_evt, cmp_a: cmp_a_evt, ovf: ovf_evt};

  // set wins over a clear in the same cycle
  wire [2:0] ack      = {irq_ack_cmpb_i, irq_ack_cmpa_i, irq_ack_ovf_i};
  wire [2:0] clr      = ack | (wr_flag ? req.wdata[2:0] : 3'h0);
  wire [2:0] flag_nxt = (flag_r & ~clr) | evt;

  // waveform: fast with com 2 sets at bottom, clears at match, com 3 the reverse; phase correct toggles via match and direction
  logic oc_a_nxt;
  logic oc_b_nxt;
  always_comb begin
    oc_a_nxt = oc_a_r;
    oc_b_nxt = oc_b_r;
    if (timer_tick) begin
      if (!mode_pwm) begin
        if (match_a && !blk_r) begin
          oc_a_nxt = (com_a == 2'h1) ? !oc_a_r : (com_a == 2'h2) ? 1'b0 : (com_a == 2'h3) ? 1'b1 : oc_a_r;
        end
        if (match_b && !blk_r) begin
          oc_b_nxt = (com_b == 2'h1) ? !oc_b_r : (com_b == 2'h2) ? 1'b0 : (com_b == 2'h3) ? 1'b1 : oc_b_r;
        end
      end else begin
        if (match_a && com_a[1]) begin
          oc_a_nxt = mode_pc ? (dir_down ? com_a[0] : !com_a[0]) : com_a[0];
        end else if (!mode_pc && at_bot && com_a[1]) begin
          oc_a_nxt = !com_a[0];
        end
        if (match_b && com_b[1]) begin
          oc_b_nxt = mode_pc ? (dir_down ? com_b[0] : !com_b[0]) : com_b[0];
        end else if (!mode_pc && at_bot && com_b[1]) begin
          oc_b_nxt = !com_b[0];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_a_r          <= TCU_RESET_VAL;
      ctrl_b_r          <= TCU_RESET_VAL;
      counter_value_r   <= TCU_RESET_VAL;
      compare_value_a_r <= TCU_RESET_VAL;
      compare_value_b_r <= TCU_RESET_VAL;
      cmp_buf_a_r       <= TCU_RESET_VAL;
      cmp_buf_b_r       <= TCU_RESET_VAL;
      mask_r            <= 3'h0;
      flag_r            <= 3'h0;
      presc_r           <= 10'h000;
      ext_prev_r        <= 1'b0;
      dir_down_r        <= 1'b0;
      blk_r             <= 1'b0;
      oc_a_r            <= 1'b0;
      oc_b_r            <= 1'b0;
    end else begin
      presc_r    <= presc_r + 10'h001;
      ext_prev_r <= external_count_pin_i;
      flag_r     <= flag_nxt;
      if (wr_ctrl_a) ctrl_a_r <= req.wdata;
      if (wr_ctrl_b) ctrl_b_r <= req.wdata;
      if (wr_mask) mask_r <= req.wdata[2:0];
      if (wr_count) begin
        counter_value_r <= req.wdata;
        blk_r           <= 1'b1;
      end else if (timer_tick) begin
        counter_value_r <= count_nxt;
        blk_r           <= 1'b0;
      end
      if (timer_tick) dir_down_r <= dir_down;
      oc_a_r <= oc_a_nxt;
      oc_b_r <= oc_b_nxt;
      if (wr_cmp_a) cmp_buf_a_r <= req.wdata;
      if (wr_cmp_b) cmp_buf_b_r <= req.wdata;
      // non-pwm modes write through; pwm modes take the buffer at the update point
      if (!mode_pwm && wr_cmp_a) begin
        compare_value_a_r <= req.wdata;
      end else if (buf_load) begin
        compare_value_a_r <= cmp_buf_a_r;
      end
      if (!mode_pwm && wr_cmp_b) begin
        compare_value_b_r <= req.wdata;
      end else if (buf_load) begin
        compare_value_b_r <= cmp_buf_b_r;
      end
    end
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    case (req.addr)
      TCU_ADDR_CTRL_A: rd_mux = ctrl_a_r;
      TCU_ADDR_CTRL_B: rd_mux = ctrl_b_r;
      TCU_ADDR_COUNT:  rd_mux = counter_value_r;
      TCU_ADDR_CMP_A:  rd_mux = mode_pwm ? cmp_buf_a_r : compare_value_a_r;
      TCU_ADDR_CMP_B:  rd_mux = mode_pwm ? cmp_buf_b_r : compare_value_b_r;
      TCU_ADDR_MASK:   rd_mux = {5'h00, mask_r};
      TCU_ADDR_FLAG:   rd_mux = {5'h00, flag_r};
      default:         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= req.rd ? rd_mux : 8'h00;
    end
  end

  assign irq_o              = |(flag_r & mask_r);
  assign compare_output_a_o = oc_a_r;
  assign compare_output_b_o = oc_b_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_stopped;
    @(posedge core_clk_i) disable iff (reset_i)
    (cs_sel == TCU_CS_STOP) && !wr_count && !reset_i |=> $stable(counter_value_r);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_wr_wins;
    @(posedge core_clk_i) disable iff (reset_i)
    wr_count |=> counter_value_r == $past(reg_wdata_i);
  endproperty
  a_wr_wins: assert property (p_wr_wins) else $error("counter write lost");

  property p_norm_step;
    @(posedge core_clk_i) disable iff (reset_i)
    (wgm == TCU_WGM_NORMAL) && timer_tick && !wr_count |=> counter_value_r == $past(counter_value_r) + TCU_ONE;
  endproperty
  a_norm_step: assert property (p_norm_step) else $error("normal mode did not count up");

  property p_ovf_wrap;
    @(posedge core_clk_i) disable iff (reset_i)
    (wgm == TCU_WGM_NORMAL) && timer_tick && !wr_count && at_max |=> flag_r[TCU_FLG_OVF] && at_bot;
  endproperty
  a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow not set on wrap");

  property p_cmp_set;
    @(posedge core_clk_i) disable iff (reset_i)
    timer_tick && match_a && !blk_r |=> flag_r[TCU_FLG_CMPA];
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("compare a flag not set");

  property p_w1c;
    @(posedge core_clk_i) disable iff (reset_i)
    wr_flag && reg_wdata_i[TCU_FLG_CMPB] && !cmp_b_evt |=> !flag_r[TCU_FLG_CMPB];
  endproperty
  a_w1c: assert property (p_w1c) else $error("compare b flag not cleared");

  property p_irq;
    @(posedge core_clk_i) disable iff (reset_i)
    flag_r[TCU_FLG_OVF] && !mask_r[TCU_FLG_OVF] && (flag_r[2:1] & mask_r[2:1]) == 2'h0 |-> !irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("masked flag raised interrupt");

  property p_ctc_clear;
    @(posedge core_clk_i) disable iff (reset_i)
    (wgm == TCU_WGM_CTC) && timer_tick && !wr_count && match_a |=> counter_value_r == TCU_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("ctc did not clear at top");

  property p_reset;
    @(posedge core_clk_i)
    reset_i |=> counter_value_r == TCU_RESET_VAL && flag_r == 3'h0 && cs_sel == TCU_CS_STOP;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  property p_reset_out;
    @(posedge core_clk_i)
    reset_i |=> !irq_o && !compare_output_a_o && !compare_output_b_o && reg_rdata_o == 8'h00;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");

  property p_rd_idle;
    @(posedge core_clk_i) disable iff (reset_i)
    !req.rd |=> reg_rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data left standing");

  property p_ext_rise;
    @(posedge core_clk_i) disable iff (reset_i)
    (cs_sel == TCU_CS_EXT_RISE) && ext_rise && (wgm == TCU_WGM_NORMAL) && !wr_count
      |=> counter_value_r == $past(counter_value_r) + TCU_ONE;
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("rising pin edge did not count");

  property p_top_down;
    @(posedge core_clk_i) disable iff (reset_i)
    mode_pc && timer_tick && at_top && !wr_count |=> counter_value_r == $past(counter_value_r) - TCU_ONE;
  endproperty
  a_top_down: assert property (p_top_down) else $error("phase correct did not turn at top");

  property p_clear_zero;
    @(posedge core_clk_i) disable iff (reset_i)
    mode_clear && timer_tick && at_top && !wr_count |=> at_bot;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear at top missed");

  property p_blk;
    @(posedge core_clk_i) disable iff (reset_i)
    blk_r && timer_tick && !flag_r[TCU_FLG_CMPA] |=> !flag_r[TCU_FLG_CMPA];
  endproperty
  a_blk: assert property (p_blk) else $error("blocked compare set its flag");

  property p_buf_hold;
    @(posedge core_clk_i) disable iff (reset_i)
    mode_pwm && wr_cmp_a && !buf_load |=> $stable(compare_value_a_r);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("compare a changed before update point");

  property p_irq_set;
    @(posedge core_clk_i) disable iff (reset_i)
    (flag_r & mask_r) != 3'h0 |-> irq_o;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("unmasked flag without interrupt");

  property p_oc_toggle;
    @(posedge core_clk_i) disable iff (reset_i)
    !mode_pwm && timer_tick && match_a && !blk_r && (com_a == 2'h1)
      |=> compare_output_a_o != $past(compare_output_a_o);
  endproperty
  a_oc_toggle: assert property (p_oc_toggle) else $error("compare output a did not toggle");

endmodule : tcu_counter_unit

`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the timer counter unit, with a counting model
// assumes tcu_pkg and tcu_cpu_model are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb;
  import tcu_pkg::*;

  logic        core_clk_i;
  logic        reset_i;
  logic [2:0]  ack_r;
  logic        pin_r;
  tcu_req_t    req;
  logic [7:0]  rdata;
  logic        irq;
  logic [15:0] lfsr_r;
  int          failures;
  int          total_checks;
  int          m_cnt;
  int          m_dir;
  logic [1:0]  oc;
  logic [1:0]  m_oc;
  int          div_q [4] = '{8, 64, 256, 1024};
  logic [2:0]  cs_q  [4] = '{TCU_CS_DIV8, TCU_CS_DIV64, TCU_CS_DIV256, TCU_CS_DIV1K};

  tcu_cpu_model tcu_cpu_model_i (.core_clk_i(core_clk_i), .reg_rdata_i(rdata), .req_o(req));

  tcu_counter_unit tcu_counter_unit_i (
    .core_clk_i(core_clk_i), .reset_i(reset_i),
    .reg_addr_i(req.addr), .reg_wdata_i(req.wdata), .reg_wr_i(req.wr), .reg_rd_i(req.rd),
    .reg_rdata_o(rdata), .irq_ack_ovf_i(ack_r[0]), .irq_ack_cmpa_i(ack_r[1]),
    .irq_ack_cmpb_i(ack_r[2]), .irq_o(irq), .external_count_pin_i(pin_r),
    .compare_output_a_o(oc[0]), .compare_output_b_o(oc[1]));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  task automatic check(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    tcu_cpu_model_i.bus_read(a, d);
    check(d, e);
  endtask : rd_chk

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    tcu_cpu_model_i.bus_write(a, d);
    tcu_cpu_model_i.bus_idle();
  endtask : wr_reg

  task automatic irq_chk(input logic e);
    @(negedge core_clk_i);
    check({7'h00, irq}, {7'h00, e});
  endtask : irq_chk

  task automatic pulse_ack(input logic [2:0] v);
    @(posedge core_clk_i) ack_r <= v;
    @(posedge core_clk_i) ack_r <= 3'h0;
  endtask : pulse_ack

  // one pin pulse gives exactly one rising and one falling edge
  task automatic tick_model(input int mode, input int top);
    @(posedge core_clk_i) pin_r <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    pin_r <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    if (mode == 1) begin
      if (m_cnt == 255) m_dir = -1;
      else if (m_cnt == 0) m_dir = 1;
      m_cnt = m_cnt + m_dir;
    end else if (m_cnt == top) m_cnt = 0;
    else m_cnt = m_cnt + 1;
  endtask : tick_model

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // ------------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  initial begin
    repeat (50000) @(posedge core_clk_i);
    failures++;
    summarize();
  end

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    reset_i = 1'b1;
    ack_r = 3'h0;
    pin_r = 1'b0;
    failures = 0;
    total_checks = 0;
    m_dir = 1;
    lfsr_r = 16'h440e;
    m_oc = 2'h0;
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'b0;
    for (int a = 0; a < 7; a++) rd_chk(4'(a), 8'h00);
    wr_reg(4'hf, 8'hff);
    rd_chk(4'hf, 8'h00);
    irq_chk(1'b0);
    wr_reg(TCU_ADDR_COUNT, 8'h5a);
    repeat (20) @(posedge core_clk_i);
    rd_chk(TCU_ADDR_COUNT, 8'h5a);
    $display("test reset and stop done");
    // overflow on both pin edges; cleared once by write, once by acknowledge
    wr_reg(TCU_ADDR_CMP_A, 8'h80);
    wr_reg(TCU_ADDR_CMP_B, 8'h81);
    for (int k = 0; k < 2; k++) begin
      wr_reg(TCU_ADDR_CTRL_B, {5'h00, (k == 0) ? TCU_CS_EXT_RISE : TCU_CS_EXT_FALL});
      wr_reg(TCU_ADDR_COUNT, 8'hfe);
      m_cnt = 254;
      repeat (2) begin
        tick_model(0, 255);
        rd_chk(TCU_ADDR_COUNT, 8'(m_cnt));
      end
      rd_chk(TCU_ADDR_FLAG, 8'h01);
      irq_chk(1'b0);
      wr_reg(TCU_ADDR_MASK, 8'h01);
      irq_chk(1'b1);
      if (k == 0) wr_reg(TCU_ADDR_FLAG, 8'h01);
      else pulse_ack(3'h1);
      rd_chk(TCU_ADDR_FLAG, 8'h00);
      irq_chk(1'b0);
      wr_reg(TCU_ADDR_MASK, 8'h00);
    end
    $display("test overflow done");
    wr_reg(TCU_ADDR_COUNT, 8'h7f);
    m_cnt = 127;
    repeat (3) tick_model(0, 255);
    rd_chk(TCU_ADDR_COUNT, 8'(m_cnt));
    rd_chk(TCU_ADDR_FLAG, 8'h06);
    wr_reg(TCU_ADDR_MASK, 8'h02);
    irq_chk(1'b1);
    pulse_ack(3'h2);
    irq_chk(1'b0);
    wr_reg(TCU_ADDR_FLAG, 8'h04);
    rd_chk(TCU_ADDR_FLAG, 8'h00);
    $display("test compare done");
    // phase correct turns round at the top, ctc clears at compare a
    wr_reg(TCU_ADDR_CTRL_A, 8'h01);
    wr_reg(TCU_ADDR_COUNT, 8'hfe);
    m_cnt = 254;
    m_dir = 1;
    repeat (3) begin
      tick_model(1, 255);
      rd_chk(TCU_ADDR_COUNT, 8'(m_cnt));
    end
    // ctc: compare a toggles its pin, compare b sets its pin
    wr_reg(TCU_ADDR_CTRL_A, 8'h72);
    wr_reg(TCU_ADDR_CMP_A, 8'h03);
    wr_reg(TCU_ADDR_CMP_B, 8'h02);
    wr_reg(TCU_ADDR_COUNT, 8'h00);
    m_cnt = 0;
    repeat (5) begin
      if (m_cnt == 3) m_oc[0] = !m_oc[0];
      if (m_cnt == 2) m_oc[1] = 1'b1;
      tick_model(2, 3);
    end
    rd_chk(TCU_ADDR_COUNT, 8'(m_cnt));
    check({6'h00, oc}, {6'h00, m_oc});
    $display("test modes done");
    // counter write lands on a running tick, stop follows with no gap
    wr_reg(TCU_ADDR_CTRL_A, 8'h00);
    wr_reg(TCU_ADDR_CTRL_B, {5'h00, TCU_CS_DIV1});
    tcu_cpu_model_i.bus_write(TCU_ADDR_COUNT, 8'h40);
    tcu_cpu_model_i.bus_write(TCU_ADDR_CTRL_B, 8'h00);
    tcu_cpu_model_i.bus_idle();
    rd_chk(TCU_ADDR_COUNT, 8'h41);
    for (int i = 0; i < 8; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      wr_reg(TCU_ADDR_COUNT, lfsr_r[7:0]);
      rd_chk(TCU_ADDR_COUNT, lfsr_r[7:0]);
      wr_reg(TCU_ADDR_MASK, {5'h00, lfsr_r[10:8]});
      rd_chk(TCU_ADDR_MASK, {5'h00, lfsr_r[10:8]});
    end
    $display("test priority and random done");
    // three periods of a divisor hold exactly three ticks, whatever the prescaler phase
    for (int d = 0; d < 4; d++) begin
      wr_reg(TCU_ADDR_COUNT, 8'h00);
      wr_reg(TCU_ADDR_CTRL_B, {5'h00, cs_q[d]});
      repeat (3 * div_q[d] - 2) @(posedge core_clk_i);
      wr_reg(TCU_ADDR_CTRL_B, 8'h00);
      rd_chk(TCU_ADDR_COUNT, 8'h03);
    end
    // fast pwm, top from compare a: the new top waits for the wrap
    wr_reg(TCU_ADDR_CTRL_A, 8'h03);
    wr_reg(TCU_ADDR_CTRL_B, 8'h08);
    wr_reg(TCU_ADDR_COUNT, 8'h00);
    wr_reg(TCU_ADDR_CMP_A, 8'h05);
    rd_chk(TCU_ADDR_CMP_A, 8'h05);
    wr_reg(TCU_ADDR_CTRL_B, 8'h0e);
    m_cnt = 0;
    repeat (4) tick_model(2, 3);
    rd_chk(TCU_ADDR_COUNT, 8'(m_cnt));
    repeat (4) tick_model(2, 5);
    rd_chk(TCU_ADDR_COUNT, 8'(m_cnt));
    wr_reg(TCU_ADDR_CTRL_B, 8'h00);
    $display("test prescaler and buffer done");
    @(posedge core_clk_i) reset_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd_chk(TCU_ADDR_COUNT, 8'h00);
    rd_chk(TCU_ADDR_MASK, 8'h00);
    check({6'h00, oc}, 8'h00);
    $display("test second reset done");
    summarize();
  end
endmodule : tb
`default_nettype wire

// >>> verification/tcu_cpu_model.sv
// cpu side model: drives the timer register port and samples read data
// assumes read data stand exactly one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

module tcu_cpu_model
  import tcu_pkg::*;
(
  // clock
  input  wire logic       core_clk_i,
  // register port
  input  wire logic [7:0] reg_rdata_i,
  output var  tcu_req_t   req_o
);
  // ------------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------------
  initial req_o = '0;

  // leaves the strobe up so a second write may follow with no gap
  task automatic bus_write(input logic [3:0] addr, input logic [7:0] data);
    @(posedge core_clk_i);
    req_o <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
  endtask : bus_write

  task automatic bus_idle();
    @(posedge core_clk_i);
    req_o <= '0;
  endtask : bus_idle

  // data sampled mid-cycle, away from the edge that clears them
  task automatic bus_read(input logic [3:0] addr, output logic [7:0] data);
    @(posedge core_clk_i);
    req_o <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    req_o <= '0;
    @(negedge core_clk_i);
    data = reg_rdata_i;
  endtask : bus_read
endmodule : tcu_cpu_model
`default_nettype wire
